// File: verilog/sdtx_pkg.sv
// Package of constants and carrier types for the serializer control and status registers
package sdtx_pkg;

  localparam int SDTX_WORD_W = 16;
  localparam int SDTX_ADDR_W = 12;
  localparam int SDTX_FLAG_W = 15;

  // Register addresses
  localparam logic [11:0] SDTX_ADDR_PROC_CTRL = 12'h000;
  localparam logic [11:0] SDTX_ADDR_ERR_STAT = 12'h001;
  localparam logic [11:0] SDTX_ADDR_EDH_EXT = 12'h002;

  // Reset values
  localparam logic [15:0] SDTX_PROC_CTRL_RST = 16'h0000;
  localparam logic [15:0] SDTX_ERR_STAT_RST = 16'h0000;
  localparam logic [15:0] SDTX_EDH_EXT_RST = 16'h0000;

  // Host-writable bits of the processing-control word
  localparam logic [15:0] SDTX_PROC_CTRL_WMASK = 16'h5fff;

  // Processing-control bit positions
  localparam int SDTX_PC_DELAY_LINE = 14;
  localparam int SDTX_PC_FLAG_SRC = 12;
  localparam int SDTX_PC_ANC_PKT_OFF = 11;
  localparam int SDTX_PC_H_TIMING = 8;
  localparam int SDTX_PC_PID_INS_OFF = 6;
  localparam int SDTX_PC_FIX_OFF = 5;
  localparam int SDTX_PC_EDH_INS_OFF = 4;
  localparam int SDTX_PC_ANC_SUM_OFF = 3;
  localparam int SDTX_PC_LINE_CHK_OFF = 2;
  localparam int SDTX_PC_LINE_NUM_OFF = 1;
  localparam int SDTX_PC_TRS_OFF = 0;

  // Error-status bit positions
  localparam int SDTX_ES_TRS_FAULT = 6;
  localparam int SDTX_ES_EDH_SUM = 5;
  localparam int SDTX_ES_SUM = 4;
  localparam int SDTX_ES_FORMAT = 3;
  localparam int SDTX_ES_RASTER = 2;
  localparam int SDTX_ES_PID_MISSING = 1;
  localparam int SDTX_ES_LOCK = 0;

  // Command word fields
  localparam int SDTX_CMD_RW = 15;
  localparam int SDTX_CMD_STEP = 12;

  // Checksum codes that never raise a fault
  localparam logic [9:0] SDTX_SUM_LOW_TOP = 10'h003;
  localparam logic [9:0] SDTX_SUM_HIGH_BASE = 10'h3fc;

  localparam logic [3:0] SDTX_LAST_BIT = 4'hf;

  typedef enum logic [1:0] {
    SDTX_IDLE = 2'b00,
    SDTX_CMD = 2'b01,
    SDTX_DATA = 2'b11,
    SDTX_HALT = 2'b10
  } sdtx_phase_t;

  // Controls towards the video datapath
  typedef struct packed {
    logic delay_line_on;
    logic edh_flag_source_sel;
    logic ancillary_packet_insert_off;
    logic smpte_h_timing;
    logic payload_id_insert_off;
    logic bad_code_fix_off;
    logic edh_check_insert_off;
    logic ancillary_sum_insert_off;
    logic line_check_insert_off;
    logic line_number_insert_off;
    logic timing_ref_insert_off;
  } sdtx_ctrl_t;

  // Level faults from the video datapath
  typedef struct packed {
    logic timing_ref_protect_fault;
    logic format_fault;
    logic raster_fault;
    logic payload_id_missing_fault;
    logic lock_fault;
  } sdtx_fault_t;

  // One checksum word seen on the output
  typedef struct packed {
    logic valid;
    logic in_edh_packet;
    logic mismatch;
    logic [9:0] value;
  } sdtx_sum_t;

endpackage : sdtx_pkg

// File: verilog/sdtx_regs.sv
// Serial-port register bank: processing control, error status and extracted EDH flags
// Function
// - Bit 14 high enables delay-line delay
// - Bit 12 selects incoming or programmed EDH flags
// - Bit 11 high disables ancillary packet insertion
// - Bit 8 selects SMPTE or active-picture H timing
// - Bit 6 high stops payload-ID insertion
// - Bit 5 high passes illegal codes unremapped
// - Bit 4 high stops EDH CRC correct/insert
// - Bit 3 high stops ancillary checksum insertion
// - HD: bit 2 stops CRC, bit 1 line numbers
// - Bit 0 high stops TRS insertion
// - Status bit 6 flags TRS protection errors
// - Status bit 4 refreshed per checksum word
// - Protected checksum codes never raise fault
// - Status bit 5 updates on EDH packets only
// - Status bit 3 flags unrecognized video standard
// - Status bit 2 flags raster/payload-ID mismatch
// - Status bit 1 flags missing payload ID
// - Status bit 0 flags PLL lock error
// - Extracted flags: three groups of five
// - Auto-increment steps the address upward; only 000h takes writes
module sdtx_regs
  import sdtx_pkg::*;
#(
  parameter int WORD_W = SDTX_WORD_W,
  parameter int ADDR_W = SDTX_ADDR_W,
  parameter int FLAG_W = SDTX_FLAG_W
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdin,
  output logic sdout,
  output logic sdout_oe,
  output sdtx_ctrl_t ctrl,
  input wire sdtx_fault_t fault_in,
  input wire sdtx_sum_t sum_in,
  input wire logic edh_rx_valid,
  input wire logic [14:0] edh_rx_flags,
  input wire logic [14:0] edh_pgm_flags,
  output logic [14:0] edh_tx_flags
);

  typedef struct packed {
    logic cs_s1;
    logic cs_s2;
    logic sck_s1;
    logic sck_s2;
    logic sck_s3;
    logic din_s1;
    logic din_s2;
    sdtx_phase_t phase;
    logic [3:0] bit_cnt;
    logic [15:0] shift_in;
    logic is_read;
    logic address_step_on;
    logic [11:0] addr;
    logic load_pend;
    logic [15:0] tx;
    logic dout;
    logic [15:0] processing_control;
    logic [15:0] error_status;
    logic [15:0] extracted_edh_flags;
    logic [14:0] tx_flags;
  } sdtx_state_t;

  sdtx_state_t st_ff;
  sdtx_state_t nxt_st;

  // The command and data word layout is fixed, so other sizes are refused
  if (WORD_W != SDTX_WORD_W) begin : g_word_w_check
    $error("sdtx_regs: WORD_W must equal the serial word width");
  end
  if (ADDR_W != SDTX_ADDR_W) begin : g_addr_w_check
    $error("sdtx_regs: ADDR_W must equal the command address width");
  end
  if (FLAG_W != SDTX_FLAG_W) begin : g_flag_w_check
    $error("sdtx_regs: FLAG_W must equal three groups of five flags");
  end

  function automatic logic [15:0] reg_read(input logic [11:0] a, input sdtx_state_t s);
    logic [15:0] v;
    v = 16'h0000;
    case (a)
      SDTX_ADDR_PROC_CTRL: v = s.processing_control;
      SDTX_ADDR_ERR_STAT: v = s.error_status;
      SDTX_ADDR_EDH_EXT: v = s.extracted_edh_flags;
      default: v = 16'h0000;
    endcase
    return v;
  endfunction : reg_read

  // Codes 000h..003h and 3FCh..3FFh are reserved, so a mismatch there is not reported
  function automatic logic sum_fault(input sdtx_sum_t s);
    return s.mismatch && (s.value > SDTX_SUM_LOW_TOP) && (s.value < SDTX_SUM_HIGH_BASE);
  endfunction : sum_fault

  logic sck_rise;
  logic sck_fall;
  logic [15:0] word_in;

  // Edges are taken between the second and third stages, never from the first
  assign sck_rise = st_ff.sck_s2 && !st_ff.sck_s3;
  assign sck_fall = !st_ff.sck_s2 && st_ff.sck_s3;
  assign word_in = {st_ff.shift_in[14:0], st_ff.din_s2};

  always_comb begin
    nxt_st = st_ff;
    nxt_st.cs_s1 = cs_n;
    nxt_st.cs_s2 = st_ff.cs_s1;
    nxt_st.sck_s1 = sclk;
    nxt_st.sck_s2 = st_ff.sck_s1;
    nxt_st.sck_s3 = st_ff.sck_s2;
    nxt_st.din_s1 = sdin;
    nxt_st.din_s2 = st_ff.din_s1;

    if (st_ff.cs_s2) begin
      // Deselect aborts any word in flight
      nxt_st.phase = SDTX_IDLE;
      nxt_st.bit_cnt = 4'h0;
      nxt_st.load_pend = 1'b0;
      nxt_st.is_read = 1'b0;
    end else begin
      case (st_ff.phase)
        SDTX_IDLE: begin
          nxt_st.phase = SDTX_CMD;
          nxt_st.bit_cnt = 4'h0;
          nxt_st.is_read = 1'b0;
        end
        SDTX_CMD, SDTX_DATA, SDTX_HALT: begin
          if (sck_rise) begin
            nxt_st.shift_in = word_in;
            nxt_st.bit_cnt = st_ff.bit_cnt + 4'h1;
            if (!st_ff.is_read) begin
              // Write traffic is echoed for daisy chains
              nxt_st.dout = st_ff.din_s2;
            end
            if (st_ff.bit_cnt == SDTX_LAST_BIT) begin
              if (st_ff.phase == SDTX_CMD) begin
                nxt_st.is_read = word_in[SDTX_CMD_RW];
                nxt_st.address_step_on = word_in[SDTX_CMD_STEP];
                nxt_st.addr = word_in[11:0];
                nxt_st.load_pend = word_in[SDTX_CMD_RW];
                nxt_st.phase = SDTX_DATA;
              end else if (st_ff.phase == SDTX_DATA) begin
                if (!st_ff.is_read && st_ff.addr == SDTX_ADDR_PROC_CTRL) begin
                  nxt_st.processing_control = word_in & SDTX_PROC_CTRL_WMASK;
                end
                if (st_ff.address_step_on) begin
                  nxt_st.addr = st_ff.addr + 12'h001;
                  nxt_st.load_pend = st_ff.is_read;
                end else begin
                  // Without auto-increment only one data word follows a command
                  nxt_st.phase = SDTX_HALT;
                end
              end
            end
          end
          if (sck_fall && st_ff.is_read) begin
            if (st_ff.load_pend) begin
              nxt_st.tx = reg_read(st_ff.addr, st_ff);
              nxt_st.load_pend = 1'b0;
              nxt_st.dout = nxt_st.tx[15];
            end else begin
              nxt_st.tx = {st_ff.tx[14:0], 1'b0};
              nxt_st.dout = st_ff.tx[14];
            end
          end
        end
        default: nxt_st.phase = SDTX_IDLE;
      endcase
    end

    nxt_st.error_status[SDTX_ES_TRS_FAULT] = fault_in.timing_ref_protect_fault;
    nxt_st.error_status[SDTX_ES_FORMAT] = fault_in.format_fault;
    nxt_st.error_status[SDTX_ES_RASTER] = fault_in.raster_fault;
    nxt_st.error_status[SDTX_ES_PID_MISSING] = fault_in.payload_id_missing_fault;
    nxt_st.error_status[SDTX_ES_LOCK] = fault_in.lock_fault;
    if (sum_in.valid) begin
      nxt_st.error_status[SDTX_ES_SUM] = sum_fault(sum_in);
      if (sum_in.in_edh_packet) begin
        nxt_st.error_status[SDTX_ES_EDH_SUM] = sum_fault(sum_in);
      end
    end

    if (edh_rx_valid) begin
      // Bits 14:10 ancillary, 9:5 full field, 4:0 active picture
      nxt_st.extracted_edh_flags = {1'b0, edh_rx_flags};
    end
    nxt_st.tx_flags = st_ff.processing_control[SDTX_PC_FLAG_SRC] ?
      st_ff.extracted_edh_flags[14:0] : edh_pgm_flags;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_ff <= '0;
      st_ff.cs_s1 <= 1'b1;
      st_ff.cs_s2 <= 1'b1;
      st_ff.phase <= SDTX_IDLE;
      st_ff.processing_control <= SDTX_PROC_CTRL_RST;
      st_ff.error_status <= SDTX_ERR_STAT_RST;
      st_ff.extracted_edh_flags <= SDTX_EDH_EXT_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign sdout = st_ff.dout;
  assign sdout_oe = !st_ff.cs_s2;
  assign edh_tx_flags = st_ff.tx_flags;

  assign ctrl.delay_line_on = st_ff.processing_control[SDTX_PC_DELAY_LINE];
  assign ctrl.edh_flag_source_sel = st_ff.processing_control[SDTX_PC_FLAG_SRC];
  assign ctrl.ancillary_packet_insert_off = st_ff.processing_control[SDTX_PC_ANC_PKT_OFF];
  assign ctrl.smpte_h_timing = st_ff.processing_control[SDTX_PC_H_TIMING];
  assign ctrl.payload_id_insert_off = st_ff.processing_control[SDTX_PC_PID_INS_OFF];
  assign ctrl.bad_code_fix_off = st_ff.processing_control[SDTX_PC_FIX_OFF];
  assign ctrl.edh_check_insert_off = st_ff.processing_control[SDTX_PC_EDH_INS_OFF];
  assign ctrl.ancillary_sum_insert_off = st_ff.processing_control[SDTX_PC_ANC_SUM_OFF];
  assign ctrl.line_check_insert_off = st_ff.processing_control[SDTX_PC_LINE_CHK_OFF];
  assign ctrl.line_number_insert_off = st_ff.processing_control[SDTX_PC_LINE_NUM_OFF];
  assign ctrl.timing_ref_insert_off = st_ff.processing_control[SDTX_PC_TRS_OFF];

endmodule : sdtx_regs

// File: bench/sdtx_regs_properties.sv
// Port assertions for the serial register bank
module sdtx_regs_properties
  import sdtx_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic cs_n,
  input wire logic sdout_oe,
  input wire sdtx_ctrl_t ctrl,
  input wire logic edh_rx_valid,
  input wire logic [14:0] edh_rx_flags,
  input wire logic [14:0] edh_pgm_flags,
  input wire logic [14:0] edh_tx_flags
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  property p_tx_pgm;
    !ctrl.edh_flag_source_sel |=> edh_tx_flags == $past(edh_pgm_flags);
  endproperty
  a_tx_pgm: assert property (p_tx_pgm) else $error("tx not pgm");
  property p_tx_ext;
    edh_rx_valid ##1 ctrl.edh_flag_source_sel |=> edh_tx_flags == $past(edh_rx_flags, 2);
  endproperty
  a_tx_ext: assert property (p_tx_ext) else $error("tx not ext");
  property p_tx_hold;
    (!edh_rx_valid && ctrl.edh_flag_source_sel) [*2] |=> $stable(edh_tx_flags);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx moved");
  property p_oe_on;
    $fell(cs_n) |-> ##2 sdout_oe;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("oe late");
  property p_oe_hold;
    !cs_n [*3] |-> sdout_oe;
  endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("oe off");
  property p_oe_off;
    cs_n [*3] |-> !sdout_oe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("oe on");
  // A write may only land inside a selected frame
  property p_ctrl_idle;
    cs_n [*6] |=> $stable(ctrl);
  endproperty
  a_ctrl_idle: assert property (p_ctrl_idle) else $error("ctrl moved");
  property p_ctrl_chg;
    $changed(ctrl) |-> sdout_oe;
  endproperty
  a_ctrl_chg: assert property (p_ctrl_chg) else $error("ctrl no frame");
endmodule : sdtx_regs_properties

// File: bench/sdtx_host_model.sv
// Host controller model for the serial register port
module sdtx_host_model
  import sdtx_pkg::*;
(
  input wire logic clk,
  input wire logic sdout,
  output logic cs_n,
  output logic sclk,
  output logic sdin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] rx [2];
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdin = 1'b0;
  end
  // Long low phase lets read data settle before sampling
  task automatic shift(input logic [15:0] w, output logic [15:0] r);
    for (int i = 15; i >= 0; i--) begin
      sclk = 1'b0;
      sdin = w[i];
      repeat (5) @(negedge clk);
      r[i] = sdout;
      sclk = 1'b1;
      repeat (4) @(negedge clk);
    end
  endtask : shift
  task automatic frame(input logic [15:0] cmd, input int n, input logic [15:0] d0, input logic [15:0] d1);
    logic [15:0] r;
    @(negedge clk);
    cs_n = 1'b0;
    shift(cmd, r);
    shift(d0, rx[0]);
    if (n > 1) shift(d1, rx[1]);
    sclk = 1'b0;
    repeat (5) @(negedge clk);
    cs_n = 1'b1;
    sdin = ~sdin;
    repeat (8) @(negedge clk);
  endtask : frame
endmodule : sdtx_host_model

// File: bench/sdtx_regs_tb.sv
// Bench for the serializer control and status register bank
module sdtx_regs_tb
  import sdtx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [15:0] wr;
    logic [10:0] ctl;
  } sdtx_row_t;
  logic clk, rstn, cs_n, sclk, sdin, sdout, sdout_oe, edh_rx_valid;
  sdtx_ctrl_t ctrl;
  sdtx_fault_t fault_in;
  sdtx_sum_t sum_in;
  logic [14:0] edh_rx_flags, edh_pgm_flags, edh_tx_flags;
  int num_errors = 0;
  int n_checks = 0;
  int cycles = 0;
  sdtx_row_t rows [13] = '{'{16'hffff, 11'h7ff}, '{16'h4000, 11'h400}, '{16'h1000, 11'h200},
    '{16'h0800, 11'h100}, '{16'h0100, 11'h080}, '{16'h0040, 11'h040}, '{16'h0020, 11'h020},
    '{16'h0010, 11'h010}, '{16'h0008, 11'h008}, '{16'h0004, 11'h004}, '{16'h0002, 11'h002},
    '{16'h0001, 11'h001}, '{16'ha680, 11'h000}};
  sdtx_regs u_dut (.clk, .rstn, .cs_n, .sclk, .sdin, .sdout, .sdout_oe, .ctrl, .fault_in, .sum_in,
    .edh_rx_valid, .edh_rx_flags, .edh_pgm_flags, .edh_tx_flags);
  sdtx_host_model u_host (.clk, .sdout, .cs_n, .sclk, .sdin);
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish
  task automatic stat(input sdtx_fault_t f, input logic edh, input logic [9:0] v, input logic [15:0] exp);
    fault_in = f;
    sum_in = '{1'b1, edh, 1'b1, v};
    @(negedge clk);
    sum_in.valid = 1'b0;
    u_host.frame(16'h8001, 1, 16'h0000, 16'h0000);
    check(u_host.rx[0], exp);
  endtask : stat
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  initial begin
    rstn = 1'b0;
    edh_rx_valid = 1'b0;
    fault_in = '0;
    sum_in = '0;
    edh_rx_flags = '0;
    edh_pgm_flags = 15'h0a5c;
    repeat (12) @(negedge clk);
    rstn = 1'b1;
    // Chip select must be seen high by the synchroniser before the first frame
    repeat (3) @(negedge clk);
    u_host.frame(16'h9000, 2, 16'h0000, 16'h0000);
    check(u_host.rx[0] | u_host.rx[1], 16'h0000);
    check(16'(edh_tx_flags), 16'h0a5c);
    foreach (rows[i]) begin
      u_host.frame(16'h0000, 1, rows[i].wr, 16'h0000);
      check(16'(ctrl), 16'(rows[i].ctl));
      u_host.frame(16'h8000, 1, 16'h0000, 16'h0000);
      check(u_host.rx[0], rows[i].wr & SDTX_PROC_CTRL_WMASK);
    end
    $display("control table end");
    stat(5'b10101, 1'b1, 10'h100, 16'h0075);
    stat(5'b01010, 1'b0, 10'h003, 16'h002a);
    stat(5'b00000, 1'b1, 10'h3fc, 16'h0000);
    stat(5'b00000, 1'b0, 10'h004, 16'h0010);
    $display("status end");
    u_host.frame(16'h1000, 2, 16'h1000, 16'hffff);
    check(16'(ctrl), 16'h0200);
    edh_rx_flags = 15'h2b3c;
    edh_rx_valid = 1'b1;
    @(negedge clk);
    edh_rx_valid = 1'b0;
    edh_rx_flags = 15'h7fff;
    u_host.frame(16'h9001, 2, 16'h0000, 16'h0000);
    check(u_host.rx[0], 16'h0010);
    check(u_host.rx[1], 16'h2b3c);
    check(16'(edh_tx_flags), 16'h2b3c);
    u_host.frame(16'h0000, 2, 16'h0001, 16'h0010);
    check(16'(ctrl), 16'h0001);
    check(16'(edh_tx_flags), 16'h0a5c);
    $display("flags end");
    rstn = 1'b0;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    check(16'(ctrl), 16'h0000);
    repeat (3) @(negedge clk);
    // Stepping past the last register also reads the unmapped address
    u_host.frame(16'h9002, 2, 16'h0000, 16'h0000);
    check(u_host.rx[0], 16'h0000);
    check(u_host.rx[1], 16'h0000);
    $display("reset end");
    tally_and_finish();
  end
endmodule : sdtx_regs_tb
bind sdtx_regs sdtx_regs_properties u_chk (.clk, .rstn, .cs_n, .sdout_oe, .ctrl, .edh_rx_valid,
  .edh_rx_flags, .edh_pgm_flags, .edh_tx_flags);
